// [logic/urls_params.svh]
// Constants for the request-to-send and line status block
`ifndef URLS_PARAMS_SVH
`define URLS_PARAMS_SVH
// Register byte addresses
`define URLS_MCR_ADDR 32'h5000_1110
`define URLS_LSR_ADDR 32'h5000_1114
`define URLS_IER_ADDR 32'h5000_1120
`define URLS_FCR_ADDR 32'h5000_1124
`define URLS_IST_ADDR 32'h5000_1128
`define URLS_IMK_ADDR 32'h5000_112c
// Modem control fields
`define URLS_MCR_RTS 1
`define URLS_MCR_LB 4
`define URLS_MCR_AFCE 5
// FIFO control fields
`define URLS_FCR_FEN 0
`define URLS_FCR_TXT 4
`define URLS_FCR_RXT 6
// Interrupt enable fields
`define URLS_IER_ETX 1
`define URLS_IER_PTIME 7
// Interrupt status bits
`define URLS_IRQ_TXE 0
`define URLS_IRQ_RFE 1
// Writable bit masks
`define URLS_MCR_WMASK 16'h0012
`define URLS_AFCE_WMASK 16'h0020
`define URLS_FCR_WMASK 16'h00f1
`define URLS_IER_WMASK 16'h0082
`define URLS_IRQ_WMASK 16'h0003
// Reset values
`define URLS_REG_RST 16'h0000
`define URLS_TEMT_RST 1'b1
`define URLS_THRE_RST 1'b1
// Auto flow option present
`define URLS_AUTO_FLOW_OPTION 1'b1
// Transmit FIFO thresholds, in characters
`define URLS_TXT_0 5'h00
`define URLS_TXT_1 5'h02
`define URLS_TXT_2 5'h04
`define URLS_TXT_3 5'h08
// Receive FIFO triggers, in characters
`define URLS_RXT_0 5'h01
`define URLS_RXT_1 5'h04
`define URLS_RXT_2 5'h08
`define URLS_RXT_3 5'h0e
// Bus responses
`define URLS_RESP_OKAY 2'h0
`define URLS_RESP_SLVERR 2'h2
`endif

// [logic/urls_pkg.sv]
// Types shared by the request-to-send and line status block
package urls_pkg;
	typedef logic [31:0] urls_addr_t;  // Bus address
	typedef logic [31:0] urls_data_t;  // Bus data
	typedef logic [15:0] urls_reg_t;   // One register
	typedef logic [4:0]  urls_level_t; // FIFO fill level
endpackage : urls_pkg

// [logic/urls_sticky.sv]
// Sticky status bit where a set beats a same-cycle clear
`timescale 1ns/1ps
module urls_sticky
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Event and clear
	input  wire logic set,
	input  wire logic clr,
	// Held flag
	output logic      q
);
	// Set has priority so no event is lost
	always_ff @(posedge clk)
	begin
		if (reset)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end

	// A set always leaves the flag high
	sticky_set_a: assert property (@(posedge clk) disable iff (reset) set |=> q)
		else $error("sticky bit lost an event");
endmodule : urls_sticky

// [logic/urls_rfe_track.sv]
// Receive FIFO error flag with a count of errored characters
`timescale 1ns/1ps
module urls_rfe_track
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// FIFO activity
	input  wire logic fifo_en,
	input  wire logic push,
	input  wire logic push_err,
	input  wire logic pop,
	input  wire logic head_err,
	// Status read strobe
	input  wire logic status_read,
	// Error flag
	output logic      flag
);
	import urls_pkg::*;

	urls_level_t err_count; // Errored characters queued
	logic        inc;       // Errored character enters
	logic        dec;       // Errored character leaves
	logic        clr_ok;    // Read may clear the flag

	assign inc = fifo_en && push && push_err;
	assign dec = fifo_en && pop && head_err;
	assign clr_ok = (err_count == 5'h00) || (head_err && err_count == 5'h01); // RQ6

	// Count of errored characters in the FIFO
	always_ff @(posedge clk)
	begin
		if (reset || !fifo_en)
			err_count <= 5'h00;
		else if (inc && !dec)
			err_count <= err_count + 5'h01;
		else if (dec && !inc && err_count != 5'h00)
			err_count <= err_count - 5'h01;
	end

	// Flag sets on an errored entry, clears on a qualifying read or when FIFOs are disabled
	always_ff @(posedge clk)
	begin
		if (reset || !fifo_en)
			flag <= 1'b0;
		else if (inc)
			flag <= 1'b1; // RQ5
		else if (status_read && clr_ok)
			flag <= 1'b0; // RQ6
	end

	// Later errors keep the flag through a read
	rfe_keep_a: assert property (@(posedge clk) disable iff (reset) // RQ6
		(flag && fifo_en && status_read && err_count > 5'h01) |=> flag)
		else $error("error flag cleared with errors still queued");
endmodule : urls_rfe_track

// [logic/urls_top.sv]
// Request-to-send control and upper line status with an AXI4-Lite slave
// Operation
// [RQ1] Control bit one drives request-to-send low
// [RQ2] Clearing control bit deasserts request-to-send
// [RQ3] Auto flow forces request-to-send high above threshold
// [RQ4] Loopback holds pin high, routes bit inside
// [RQ5] FIFO error flag set by errored characters
// [RQ6] Error flag clears only when last at head
// [RQ7] FIFO mode: empty when FIFO and shifter empty
// [RQ8] Non-FIFO mode: empty when holding and shifter empty
// [RQ9] Bit five shows holding or FIFO empty
// [RQ10] Holding empty sets on move into shifter
// [RQ11] Holding empty raises enabled interrupt
// [RQ12] Programmable mode shows FIFO full, threshold interrupts
// [RQ13] Auto flow acts only with FIFOs enabled
// [RQ14] Control bit four selects diagnostic loopback
// [RQ15] Reserved status and control bit zero read zero
`timescale 1ns/1ps
`include "urls_params.svh"
module urls_top
(
	// Clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 RESET,
	// AXI4-Lite write address and data
	input  wire urls_pkg::urls_addr_t AWADDR,
	input  wire logic                 AWVALID,
	output logic                      AWREADY,
	input  wire urls_pkg::urls_data_t WDATA,
	input  wire logic [3:0]           WSTRB,
	input  wire logic                 WVALID,
	output logic                      WREADY,
	// AXI4-Lite write response
	output logic [1:0]                BRESP,
	output logic                      BVALID,
	input  wire logic                 BREADY,
	// AXI4-Lite read
	input  wire urls_pkg::urls_addr_t ARADDR,
	input  wire logic                 ARVALID,
	output logic                      ARREADY,
	output urls_pkg::urls_data_t      RDATA,
	output logic [1:0]                RRESP,
	output logic                      RVALID,
	input  wire logic                 RREADY,
	// Transmit path state
	input  wire logic                 TX_WRITE,
	input  wire logic                 TX_LOAD,
	input  wire logic                 TX_FIFO_EMPTY,
	input  wire logic                 TX_FIFO_FULL,
	input  wire urls_pkg::urls_level_t TX_FIFO_LEVEL,
	input  wire logic                 TX_SHIFT_EMPTY,
	// Receive path state
	input  wire logic                 RX_PUSH,
	input  wire logic                 RX_PUSH_ERR,
	input  wire logic                 RX_POP,
	input  wire logic                 RX_HEAD_ERR,
	input  wire urls_pkg::urls_level_t RX_FIFO_LEVEL,
	// Modem side and core controls
	output logic                      RTS_N,
	output logic                      LOOP_RTS,
	output logic                      LOOPBACK_ENABLE,
	output logic                      FIFO_ENABLE,
	output logic                      IRQ
);
	import urls_pkg::*;

	// ********************************
	// Registers and decoded fields
	// ********************************
	urls_reg_t   modem_control_register;          // Modem control
	urls_reg_t   fifo_control_register;          // FIFO control
	urls_reg_t   interrupt_enable_register;          // Interrupt enable
	urls_reg_t   irq_mask;     // Interrupt mask
	logic [1:0]  irq_status;   // Sticky events
	logic        thre_flag;    // Holding empty
	logic        temt_flag;    // Transmitter empty
	logic        rfe_flag;     // Receive FIFO error
	logic        rfe_q;        // Previous error flag
	logic        tx_at_thr_q;  // Previous threshold state
	urls_addr_t  aw_addr;      // Held write address
	urls_data_t  w_data;       // Held write data
	logic [3:0]  w_strb;       // Held write strobes
	logic        aw_held;      // Address captured
	logic        w_held;       // Data captured
	logic        do_write;     // Perform write now
	logic        lsr_read;     // Status read taken
	logic        auto_active;  // Auto flow in force
	logic        rx_above;     // Receive fill above trigger
	logic        tx_at_thr;    // Transmit fill at or below threshold
	logic        thre_set;     // Holding empty event
	logic        txe_event;    // Transmit-empty interrupt event
	logic        fen;          // FIFOs enabled
	logic        ptime;        // Programmable empty mode
	logic        next_rts_n;   // Pin value
	urls_reg_t   lsr_value;    // Status as read
	urls_reg_t   wmask;        // Byte lane mask
	urls_data_t  next_rdata;   // Read mux
	logic [1:0]  next_rresp;   // Read answer
	urls_level_t tx_thr;       // Selected transmit threshold
	urls_level_t rx_trig;      // Selected receive trigger

	assign fen = fifo_control_register[`URLS_FCR_FEN];
	assign ptime = interrupt_enable_register[`URLS_IER_PTIME];
	assign wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	assign do_write = aw_held && w_held && !BVALID;
	assign lsr_read = ARVALID && ARREADY && (ARADDR == `URLS_LSR_ADDR);

	// ********************************
	// AXI4-Lite write channel
	// ********************************
	// Address capture, released once the write is done
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			AWREADY <= 1'b0;
			aw_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
		end
		else if (AWVALID && AWREADY)
		begin
			AWREADY <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= AWADDR;
		end
		else if (do_write)
			aw_held <= 1'b0;
		else if (!aw_held && !BVALID)
			AWREADY <= 1'b1;
	end

	// Data capture, independent of the address
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			WREADY <= 1'b0;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (WVALID && WREADY)
		begin
			WREADY <= 1'b0;
			w_held <= 1'b1;
			w_data <= WDATA;
			w_strb <= WSTRB;
		end
		else if (do_write)
			w_held <= 1'b0;
		else if (!w_held && !BVALID)
			WREADY <= 1'b1;
	end

	// Write response, error for unmapped addresses
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			BVALID <= 1'b0;
			BRESP <= `URLS_RESP_OKAY;
		end
		else if (do_write)
		begin
			BVALID <= 1'b1;
			unique case (aw_addr)
				`URLS_MCR_ADDR, `URLS_LSR_ADDR, `URLS_IER_ADDR,
				`URLS_FCR_ADDR, `URLS_IST_ADDR, `URLS_IMK_ADDR:
					BRESP <= `URLS_RESP_OKAY;
				default:
					BRESP <= `URLS_RESP_SLVERR;
			endcase
		end
		else if (BREADY)
			BVALID <= 1'b0;
	end

	// ********************************
	// Software registers
	// ********************************
	// Control registers, writable bits only
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			modem_control_register <= `URLS_REG_RST;
			fifo_control_register <= `URLS_REG_RST;
			interrupt_enable_register <= `URLS_REG_RST;
			irq_mask <= `URLS_REG_RST;
		end
		else if (do_write)
		begin
			// Only loopback, request-to-send and gated auto flow are held
			if (aw_addr == `URLS_MCR_ADDR) // RQ15
				modem_control_register <= (modem_control_register & ~(wmask & (`URLS_MCR_WMASK
					| (`URLS_AUTO_FLOW_OPTION ? `URLS_AFCE_WMASK : 16'h0000))))
					| (w_data[15:0] & wmask & (`URLS_MCR_WMASK
					| (`URLS_AUTO_FLOW_OPTION ? `URLS_AFCE_WMASK : 16'h0000)));
			if (aw_addr == `URLS_FCR_ADDR)
				fifo_control_register <= (fifo_control_register & ~(wmask & `URLS_FCR_WMASK))
					| (w_data[15:0] & wmask & `URLS_FCR_WMASK);
			if (aw_addr == `URLS_IER_ADDR)
				interrupt_enable_register <= (interrupt_enable_register & ~(wmask & `URLS_IER_WMASK))
					| (w_data[15:0] & wmask & `URLS_IER_WMASK);
			if (aw_addr == `URLS_IMK_ADDR)
				irq_mask <= (irq_mask & ~(wmask & `URLS_IRQ_WMASK))
					| (w_data[15:0] & wmask & `URLS_IRQ_WMASK);
		end
	end

	// ********************************
	// Request-to-send and loopback
	// ********************************
	// Receive trigger from the FIFO control field
	always_comb
	begin
		unique case (fifo_control_register[`URLS_FCR_RXT +: 2])
			2'h0: rx_trig = `URLS_RXT_0;
			2'h1: rx_trig = `URLS_RXT_1;
			2'h2: rx_trig = `URLS_RXT_2;
			2'h3: rx_trig = `URLS_RXT_3;
		endcase
	end

	assign rx_above = RX_FIFO_LEVEL > rx_trig;
	assign auto_active = modem_control_register[`URLS_MCR_AFCE] && fen; // RQ13

	// Pin is low only when asked for and not overridden
	always_comb
	begin
		if (modem_control_register[`URLS_MCR_LB])
			next_rts_n = 1'b1; // RQ4
		else if (!modem_control_register[`URLS_MCR_RTS])
			next_rts_n = 1'b1; // RQ2
		else if (auto_active && rx_above)
			next_rts_n = 1'b1; // RQ3
		else
			next_rts_n = 1'b0; // RQ1
	end

	// Modem side outputs
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			RTS_N <= 1'b1;
			LOOP_RTS <= 1'b0;
			LOOPBACK_ENABLE <= 1'b0;
			FIFO_ENABLE <= 1'b0;
		end
		else
		begin
			RTS_N <= next_rts_n;
			LOOP_RTS <= modem_control_register[`URLS_MCR_LB] && modem_control_register[`URLS_MCR_RTS]; // RQ4
			LOOPBACK_ENABLE <= modem_control_register[`URLS_MCR_LB]; // RQ14
			FIFO_ENABLE <= fen;
		end
	end

	// ********************************
	// Transmit status
	// ********************************
	// Without FIFOs the FIFO empty input covers the single holding slot
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
			temt_flag <= `URLS_TEMT_RST;
		else
			temt_flag <= TX_FIFO_EMPTY && TX_SHIFT_EMPTY; // RQ7 RQ8
	end

	// A fresh write keeps the holding slot occupied
	assign thre_set = TX_LOAD && TX_FIFO_EMPTY && !TX_WRITE;

	// Holding empty tracks moves into the shifter and new writes
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
			thre_flag <= `URLS_THRE_RST;
		else if (TX_WRITE)
			thre_flag <= 1'b0;
		else if (thre_set)
			thre_flag <= 1'b1; // RQ10
	end

	// Transmit threshold from the FIFO control field
	always_comb
	begin
		unique case (fifo_control_register[`URLS_FCR_TXT +: 2])
			2'h0: tx_thr = `URLS_TXT_0;
			2'h1: tx_thr = `URLS_TXT_1;
			2'h2: tx_thr = `URLS_TXT_2;
			2'h3: tx_thr = `URLS_TXT_3;
		endcase
	end

	assign tx_at_thr = TX_FIFO_LEVEL <= tx_thr;

	// Edge memories for interrupt events
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			tx_at_thr_q <= 1'b1;
			rfe_q <= 1'b0;
		end
		else
		begin
			tx_at_thr_q <= tx_at_thr;
			rfe_q <= rfe_flag;
		end
	end

	// Event source depends on programmable mode
	assign txe_event = interrupt_enable_register[`URLS_IER_ETX] && ((ptime && fen)
		? (tx_at_thr && !tx_at_thr_q) // RQ12
		: thre_set); // RQ11

	// ********************************
	// Receive error flag
	// ********************************
	urls_rfe_track u_rfe
	(
		.clk         (REF_CLK),
		.reset       (RESET),
		.fifo_en     (fen),
		.push        (RX_PUSH),
		.push_err    (RX_PUSH_ERR),
		.pop         (RX_POP),
		.head_err    (RX_HEAD_ERR),
		.status_read (lsr_read),
		.flag        (rfe_flag)
	);

	// ********************************
	// Interrupts
	// ********************************
	// Sticky events cleared by writing a one
	urls_sticky u_irq_txe
	(
		.clk   (REF_CLK),
		.reset (RESET),
		.set   (txe_event),
		.clr   (do_write && aw_addr == `URLS_IST_ADDR && w_strb[0]
			&& w_data[`URLS_IRQ_TXE]),
		.q     (irq_status[`URLS_IRQ_TXE])
	);

	urls_sticky u_irq_rfe
	(
		.clk   (REF_CLK),
		.reset (RESET),
		.set   (rfe_flag && !rfe_q),
		.clr   (do_write && aw_addr == `URLS_IST_ADDR && w_strb[0]
			&& w_data[`URLS_IRQ_RFE]),
		.q     (irq_status[`URLS_IRQ_RFE])
	);

	// Level output from unmasked status
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_status & irq_mask[1:0]);
	end

	// ********************************
	// AXI4-Lite read channel
	// ********************************
	// Status view, reserved upper byte reads zero
	assign lsr_value = {8'h00, rfe_flag && fen, temt_flag, // RQ15 RQ5
		(ptime && fen) ? TX_FIFO_FULL : thre_flag, 5'h00}; // RQ12 RQ9

	// Read mux by address
	always_comb
	begin
		next_rresp = `URLS_RESP_OKAY;
		unique case (ARADDR)
			`URLS_MCR_ADDR: next_rdata = {16'h0000, modem_control_register};
			`URLS_LSR_ADDR: next_rdata = {16'h0000, lsr_value};
			`URLS_IER_ADDR: next_rdata = {16'h0000, interrupt_enable_register};
			`URLS_FCR_ADDR: next_rdata = {16'h0000, fifo_control_register};
			`URLS_IST_ADDR: next_rdata = {30'h0000_0000, irq_status};
			`URLS_IMK_ADDR: next_rdata = {16'h0000, irq_mask};
			default:
			begin
				next_rdata = 32'h0000_0000;
				next_rresp = `URLS_RESP_SLVERR;
			end
		endcase
	end

	// Address taken and answered on the next cycle
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `URLS_RESP_OKAY;
		end
		else if (ARVALID && ARREADY)
		begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
		end
		else if (RVALID && RREADY)
			RVALID <= 1'b0;
		else if (!RVALID)
			ARREADY <= 1'b1;
	end

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);

	rts_manual_a: assert property ( // RQ1
		(modem_control_register[`URLS_MCR_RTS] && !modem_control_register[`URLS_MCR_LB] && !(auto_active && rx_above)) |=> !RTS_N)
		else $error("request-to-send not asserted");
	rts_clear_a: assert property (!modem_control_register[`URLS_MCR_RTS] |=> RTS_N) // RQ2
		else $error("request-to-send not released");
	rts_auto_a: assert property ((auto_active && rx_above) |=> RTS_N) // RQ3
		else $error("auto flow did not hold request-to-send");
	loop_hold_a: assert property (modem_control_register[`URLS_MCR_LB] // RQ4
		|=> RTS_N && LOOP_RTS == $past(modem_control_register[`URLS_MCR_RTS]))
		else $error("loopback routing wrong");
	rfe_gate_a: assert property (!fen |-> !lsr_value[7]) // RQ5
		else $error("error flag shown without FIFOs");
	temt_track_a: assert property ((TX_FIFO_EMPTY && TX_SHIFT_EMPTY) // RQ7 RQ8
		|=> temt_flag && lsr_value[6])
		else $error("transmitter empty not shown");
	thre_set_a: assert property (thre_set |=> thre_flag) // RQ10
		else $error("holding empty not set");
	thre_view_a: assert property (!ptime |-> lsr_value[5] == thre_flag) // RQ9
		else $error("holding empty view wrong");
	thre_irq_a: assert property ( // RQ11
		(thre_set && interrupt_enable_register[`URLS_IER_ETX] && !ptime && irq_mask[`URLS_IRQ_TXE]) |=> ##1 IRQ)
		else $error("transmit-empty interrupt missing");
	ptime_full_a: assert property ((ptime && fen) // RQ12
		|-> lsr_value[5] == TX_FIFO_FULL)
		else $error("programmable mode not showing full");
	afce_gate_a: assert property ( // RQ13
		(!fen && modem_control_register[`URLS_MCR_RTS] && !modem_control_register[`URLS_MCR_LB]) |=> !RTS_N)
		else $error("auto flow acted without FIFOs");
	loop_out_a: assert property (##1 LOOPBACK_ENABLE == $past(modem_control_register[`URLS_MCR_LB])) // RQ14
		else $error("loopback output wrong");
	reserved_a: assert property (lsr_value[15:8] == 8'h00 && !modem_control_register[0]) // RQ15
		else $error("reserved bits not zero");
endmodule : urls_top

// [bench/urls_modem.sv]
// Data set model that watches the request-to-send line
`timescale 1ns/1ps
module urls_modem
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// Request line from the device, active low
	input  wire logic rts_n,
	// Set while the data set sees a request to exchange data
	output logic      peer_go
);
	// ****
	// Samples the line once a clock, as a real data set would
	// ****
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			peer_go <= 1'b0;
		else
			peer_go <= !rts_n;
	end
endmodule : urls_modem

// [bench/urls_top_bench.sv]
// Self-checking bench for the request-to-send and line status block
`timescale 1ns/1ps
`include "urls_params.svh"
module urls_top_bench;
	import urls_pkg::*;
	// ****
	// Signals
	// ****
	logic ref_clk = 1'b0, reset = 1'b1;
	urls_addr_t awaddr = '0, araddr = '0;
	urls_data_t wdata = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf; // Write byte lanes
	logic awready, wready, bvalid, arready, rvalid, irq, rts_n, loop_rts, lb_en, fifo_en, peer_go;
	logic [1:0] bresp, rresp;
	logic tx_write = 1'b0, tx_load = 1'b0, tx_fifo_empty = 1'b1, tx_fifo_full = 1'b0;
	logic tx_shift_empty = 1'b1;
	logic rx_push = 1'b0, rx_push_err = 1'b0, rx_pop = 1'b0, rx_head_err = 1'b0;
	urls_level_t tx_level = '0, rx_level = '0;
	logic [33:0] exp_q[$];   // Expected read response and data, oldest first
	int n_errors = 0, comparisons = 0, cycles = 0;
	integer seed = 32'h8003;
	logic [31:0] v;
	int trg[4] = '{1, 4, 8, 14};
	urls_level_t txt[4] = '{`URLS_TXT_0, `URLS_TXT_1, `URLS_TXT_2, `URLS_TXT_3};
	// 20 MHz clock
	always #25 ref_clk = !ref_clk;
	urls_top dut_u (.REF_CLK(ref_clk), .RESET(reset), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.TX_WRITE(tx_write), .TX_LOAD(tx_load), .TX_FIFO_EMPTY(tx_fifo_empty),
		.TX_FIFO_FULL(tx_fifo_full), .TX_FIFO_LEVEL(tx_level), .TX_SHIFT_EMPTY(tx_shift_empty),
		.RX_PUSH(rx_push), .RX_PUSH_ERR(rx_push_err), .RX_POP(rx_pop), .RX_HEAD_ERR(rx_head_err),
		.RX_FIFO_LEVEL(rx_level), .RTS_N(rts_n), .LOOP_RTS(loop_rts), .LOOPBACK_ENABLE(lb_en),
		.FIFO_ENABLE(fifo_en), .IRQ(irq));
	urls_modem modem_u (.ref_clk(ref_clk), .reset(reset), .rts_n(rts_n), .peer_go(peer_go));
	// ****
	// Helpers
	// ****
	// One comparison, counted
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// Write one register; waits for the response, the hang guard ends a stall
	task automatic wr(input urls_addr_t a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, bresp});
	endtask : wr
	// Read one register; the monitor compares the data
	task automatic rd(input urls_addr_t a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, 16'h0000, d});
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
	endtask : rd
	// Read monitor: oldest note against each data beat
	always @(posedge ref_clk)
	begin
		if (rvalid && rready)
		begin
			if (exp_q.size() == 0)
			begin
				n_errors++;
				$display("CHECK FAILED rdata expected none seen %h", rdata);
			end
			else
			begin
				chk("rresp", {30'h0, exp_q[0][33:32]}, {30'h0, rresp});
				chk("rdata", exp_q[0][31:0], rdata);
				void'(exp_q.pop_front());
			end
		end
	end
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// Hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	// ****
	// Scenarios
	// ****
	initial
	begin
		tick(20);
		reset <= 1'b0;
		tick(3);
		rd(`URLS_LSR_ADDR, 16'h0060);
		rd(32'h5000_1100, 16'h0000, `URLS_RESP_SLVERR);
		wr(32'h5000_1100, 16'hffff, `URLS_RESP_SLVERR);
		wr(`URLS_LSR_ADDR, 16'hffff);
		rd(`URLS_LSR_ADDR, 16'h0060);
		repeat (3)
		begin
			v = $random(seed);
			wr(`URLS_MCR_ADDR, v[15:0]);
			rd(`URLS_MCR_ADDR, v[15:0] & 16'h0032);
		end
		// Low byte lane off: the write must leave the register alone
		wstrb <= 4'he;
		wr(`URLS_MCR_ADDR, 16'h0000);
		wstrb <= 4'hf;
		rd(`URLS_MCR_ADDR, v[15:0] & 16'h0032);
		wr(`URLS_MCR_ADDR, 16'h0002);
		tick(3);
		chk("peer_go", 1, peer_go);
		wr(`URLS_MCR_ADDR, 16'h0000);
		tick(2);
		chk("rts_n", 1, rts_n);
		chk("peer_go", 0, peer_go);
		// Each receive trigger, at and just above its level
		for (int i = 0; i < 4; i++)
		begin
			wr(`URLS_FCR_ADDR, 16'h0001 | 16'(i << 6));
			wr(`URLS_MCR_ADDR, 16'h0022);
			rx_level <= 5'(trg[i]);
			tick(3);
			chk("rts_n", 0, rts_n);
			rx_level <= 5'(trg[i] + 1);
			tick(3);
			chk("rts_n", 1, rts_n);
		end
		rx_level <= 5'h00;
		wr(`URLS_MCR_ADDR, 16'h0020);
		tick(2);
		chk("rts_n", 1, rts_n);
		wr(`URLS_FCR_ADDR, 16'h0000);
		wr(`URLS_MCR_ADDR, 16'h0022);
		chk("fifo_en", 0, fifo_en);
		rx_level <= 5'h1f;
		tick(3);
		chk("rts_n", 0, rts_n);
		wr(`URLS_MCR_ADDR, 16'h0012);
		tick(2);
		chk("rts_n", 1, rts_n);
		chk("loop_rts", 1, loop_rts);
		chk("lb_en", 1, lb_en);
		wr(`URLS_MCR_ADDR, 16'h0010);
		tick(2);
		chk("loop_rts", 0, loop_rts);
		wr(`URLS_MCR_ADDR, 16'h0000);
		// Transmitter empty in both modes
		tx_shift_empty <= 1'b0;
		rd(`URLS_LSR_ADDR, 16'h0020);
		tx_shift_empty <= 1'b1;
		tx_fifo_empty <= 1'b0;
		rd(`URLS_LSR_ADDR, 16'h0020);
		wr(`URLS_FCR_ADDR, 16'h0001);
		rd(`URLS_LSR_ADDR, 16'h0020);
		chk("fifo_en", 1, fifo_en);
		chk("lb_en", 0, lb_en);
		tx_fifo_empty <= 1'b1;
		rd(`URLS_LSR_ADDR, 16'h0060);
		// Holding empty and its interrupt, unmasked then masked
		wr(`URLS_IST_ADDR, 16'h0003);
		wr(`URLS_IER_ADDR, 16'h0002);
		for (int m = 1; m >= 0; m--)
		begin
			wr(`URLS_IMK_ADDR, 16'(m));
			tx_write <= 1'b1;
			tick(1);
			tx_write <= 1'b0;
			rd(`URLS_LSR_ADDR, 16'h0040);
			tx_load <= 1'b1;
			tick(1);
			tx_load <= 1'b0;
			tick(3);
			chk("irq", m, irq);
			rd(`URLS_LSR_ADDR, 16'h0060);
			rd(`URLS_IST_ADDR, 16'h0001);
			wr(`URLS_IST_ADDR, 16'h0001);
			tick(2);
			chk("irq", 0, irq);
		end
		// Two errored characters, then cleared only when the last is at the head
		rx_push <= 1'b1;
		rx_push_err <= 1'b1;
		tick(2);
		rx_push <= 1'b0;
		rd(`URLS_LSR_ADDR, 16'h00e0);
		rd(`URLS_LSR_ADDR, 16'h00e0);
		rx_head_err <= 1'b1;
		rx_pop <= 1'b1;
		tick(1);
		rx_pop <= 1'b0;
		rd(`URLS_LSR_ADDR, 16'h00e0);
		rd(`URLS_LSR_ADDR, 16'h0060);
		// Programmable mode: full flag and threshold interrupt
		wr(`URLS_IST_ADDR, 16'h0003);
		wr(`URLS_IMK_ADDR, 16'h0001);
		wr(`URLS_IER_ADDR, 16'h0082);
		wr(`URLS_FCR_ADDR, 16'h0011);
		tx_fifo_empty <= 1'b0;
		tx_fifo_full <= 1'b1;
		tx_level <= 5'h03;
		rd(`URLS_LSR_ADDR, 16'h0020);
		tx_fifo_full <= 1'b0;
		rd(`URLS_LSR_ADDR, 16'h0000);
		chk("irq", 0, irq);
		tx_level <= 5'h02;
		tick(3);
		chk("irq", 1, irq);
		// Every transmit threshold: fill drops to it and raises the interrupt
		for (int i = 0; i < 4; i++)
		begin
			wr(`URLS_FCR_ADDR, 16'h0001 | 16'(i << 4));
			tx_level <= txt[i] + 5'h01;
			tick(3);
			wr(`URLS_IST_ADDR, 16'h0001);
			tick(2);
			chk("irq", 0, irq);
			tx_level <= txt[i];
			tick(3);
			chk("irq", 1, irq);
		end
		tick(5);
		wrap_up();
	end
endmodule : urls_top_bench
